// >>> src/irq_timer_pkg.sv
/*
 * Constants, enumerations and I/O offsets of the interrupt and tick timer block.
 * Assumes a single system clock and a plain I/O register port carrying byte data.
 */
// How it works
// - Timer input 0, serial ports inputs 3, 4.
// - Shared pci line a drives input 5.
// - Routing registers: line a request 5, others disabled.
// - Two priority orders: 0,3,4,5 or 3,4,5,0.
// - Special mask blocks only the masked level.
// - In-service bit blocks lower priorities otherwise.
// - Auto end clears in-service on second acknowledge.
// - Otherwise specific end command clears in-service.
// - Poll command is not implemented.
// - Fully nested mode is not implemented.
// - Level requests of one clock are captured.
// - Mask gates request register bit by bit.
// - Slave registers only store and read back.
// - System error status bit 7; bit 2 disables.
// - Nmi enable bit 7 blocks; re-enable re-raises.
// - Only counter 0, rate generator, binary.
// - Latch command 1100 freezes count until read.
// - Read-back command is not implemented.
// - Tick high one timer clock at count 1.
// - Timer enable divides system clock by 27/28.
// - Pattern 27/28/28 cycles 0-33, then 27/27/28.
// - Clock address port bits 6:0 held locally.
package irq_timer_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADR_MCMD   = 12'h020;
    localparam logic [11:0] ADR_MDATA  = 12'h021;
    localparam logic [11:0] ADR_SCMD   = 12'h0a0;
    localparam logic [11:0] ADR_SDATA  = 12'h0a1;
    localparam logic [11:0] ADR_CNT0   = 12'h040;
    localparam logic [11:0] ADR_TCTL   = 12'h043;
    localparam logic [11:0] ADR_NMISC  = 12'h061;
    localparam logic [11:0] ADR_NMIEN  = 12'h070;
    localparam logic [11:0] ADR_ROUTE_A = 12'h060;
    localparam logic [11:0] ADR_ROUTE_B = 12'h068;
    localparam logic [11:0] ADR_ROUTE_C = 12'h069;
    localparam logic [11:0] ADR_ROUTE_D = 12'h06a;
    localparam logic [7:0] ROUTE_A_VAL   = 8'h05;
    localparam logic [7:0] ROUTE_OFF_VAL = 8'h80;
    localparam int NIRQ = 8;
    localparam logic [2:0] IN_TMR  = 3'h0;
    localparam logic [2:0] IN_SER1 = 3'h3;
    localparam logic [2:0] IN_SER2 = 3'h4;
    localparam logic [2:0] IN_NET  = 3'h5;
    localparam int B_INIT   = 4;
    localparam int B_OCW3   = 3;
    localparam int B_AEOI   = 1;
    localparam int B_SMM    = 5;
    localparam int B_SMMSET = 6;
    localparam int B_NMIST  = 7;
    localparam int B_NMIOFF = 2;
    localparam int B_NMIEN  = 7;
    localparam logic [2:0] EOI_SPEC = 3'h3;
    localparam logic [2:0] ROT_SET  = 3'h6;
    localparam logic [1:0] RW_LATCH = 2'h0;
    localparam logic [1:0] RW_LSB   = 2'h1;
    localparam logic [1:0] RW_MSB   = 2'h2;
    localparam logic [3:0] LATCH_CMD = 4'hc;
    localparam logic [4:0] DIV_A = 5'd27;
    localparam logic [4:0] DIV_B = 5'd28;
    localparam logic [5:0] LAST_CYC = 6'd34;
    localparam logic [7:0] MASK_RST = 8'hff;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_IW2 = 4'b0010, ST_IW3 = 4'b0100, ST_IW4 = 4'b1000
    } init_st_t;
endpackage

// >>> src/irq_timer.sv
/*
 * Interrupt controller, system error logic and tick timer behind one I/O port.
 * Assumes the processor issues strobes of one cycle and takes read data next cycle.
 */
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module irq_timer (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Register port.
    input  wire logic [11:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    // Interrupt sources and acknowledge.
    input  wire logic        i_ser1_irq,
    input  wire logic        i_ser2_irq,
    input  wire logic        i_pci_irq_a,
    input  wire logic        i_serr,
    input  wire logic        i_inta,
    // Processor outputs.
    output logic             o_intr,
    output logic             o_nmi,
    output logic      [7:0]  o_vector,
    output logic             o_tick
);
    logic [7:0] irr_r, imr_r, isr_r, vbase_r, svbase_r, simr_r, sicw_r;
    logic       aeoi_r, smm_r, alt_r, inta_ph_r, inta_d_r, intr_r, nmi_r;
    logic [2:0] sel_r;
    logic [7:0] rdata_r, vec_r;
    logic [7:0] nmisc_r;
    logic       nmien_r;
    logic [6:0] cmos_r;
    logic       sinit_r;
    logic [1:0] sst_r;
    logic       serr_d_r, en_d_r;
    irq_timer_pkg::init_st_t st_r;
    // Timer state.
    logic [15:0] cnt_r, init_r, latch_r;
    logic [1:0]  rwm_r;
    logic        latched_r, lo_next_r, rlo_next_r, run_r, tick_r;
    logic [7:0]  lsb_r;
    logic [4:0]  div_r;
    logic [1:0]  sub_r;
    logic [5:0]  cyc_r;

    // Request inputs per controller line.
    wire [7:0] raw_irq;
    assign raw_irq = {2'b00, i_pci_irq_a, i_ser2_irq, i_ser1_irq, 2'b00, tick_r};

    // Rank of a line: smaller is higher priority.
    function automatic logic [2:0] rank(input logic [2:0] n, input logic alt);
        case (n)
            3'd0:    rank = alt ? 3'd3 : 3'd0;
            3'd3:    rank = alt ? 3'd0 : 3'd1;
            3'd4:    rank = alt ? 3'd1 : 3'd2;
            3'd5:    rank = alt ? 3'd2 : 3'd3;
            default: rank = 3'd7;
        endcase
    endfunction

    // Best line in a set of bits, with a flag for any.
    function automatic logic [3:0] best(input logic [7:0] v, input logic alt);
        logic [2:0] b;
        logic       f;
        b = 3'd0;
        f = 1'b0;
        for (int i = 0; i < irq_timer_pkg::NIRQ; i++) begin
            if (v[i] && (!f || rank(3'(i), alt) < rank(b, alt))) begin
                b = 3'(i);
                f = 1'b1;
            end
        end
        best = {f, b};
    endfunction

    // Candidate selection with masking and in-service blocking.
    wire [7:0] pend  = irr_r & ~imr_r;
    wire [7:0] isr_v = smm_r ? (isr_r & ~imr_r) : isr_r;
    wire [3:0] req_b = best(pend & ~isr_r, alt_r);
    wire [3:0] isr_b = best(isr_v, alt_r);
    wire       grant = req_b[3] && (smm_r || !isr_b[3] ||
                       rank(req_b[2:0], alt_r) < rank(isr_b[2:0], alt_r));

    // Write decoding.
    wire w_mcmd  = i_wr && i_addr == irq_timer_pkg::ADR_MCMD;
    wire w_mdata = i_wr && i_addr == irq_timer_pkg::ADR_MDATA;
    wire w_scmd  = i_wr && i_addr == irq_timer_pkg::ADR_SCMD;
    wire w_sdata = i_wr && i_addr == irq_timer_pkg::ADR_SDATA;
    wire w_tctl  = i_wr && i_addr == irq_timer_pkg::ADR_TCTL;
    wire w_cnt   = i_wr && i_addr == irq_timer_pkg::ADR_CNT0;
    wire r_cnt   = i_rd && i_addr == irq_timer_pkg::ADR_CNT0;
    wire icw1    = w_mcmd && i_wdata[irq_timer_pkg::B_INIT];
    wire ocw2    = w_mcmd && !i_wdata[irq_timer_pkg::B_INIT] && !i_wdata[irq_timer_pkg::B_OCW3];
    wire ocw3    = w_mcmd && !i_wdata[irq_timer_pkg::B_INIT] && i_wdata[irq_timer_pkg::B_OCW3];
    wire spec_eoi = ocw2 && i_wdata[7:5] == irq_timer_pkg::EOI_SPEC;
    wire inta_rise = i_inta && !inta_d_r;
    wire ack1 = inta_rise && !inta_ph_r;
    wire ack2 = inta_rise && inta_ph_r;
    // Each acknowledge set with latched line.
    wire [7:0] sel_bit = 8'h01 << sel_r;
    wire [7:0] eoi_bit = 8'h01 << i_wdata[2:0];

    // Request register: set wins over acknowledge clear.
    always_ff @(posedge i_clk) begin
        if (i_rst) irr_r <= '0;
        else irr_r <= (irr_r & ~(ack1 ? sel_bit : 8'h00)) | raw_irq;
    end

    // In-service register; a new acknowledge wins over a clear in the same cycle.
    always_ff @(posedge i_clk) begin
        if (i_rst || icw1) begin
            isr_r <= '0;
        end else begin
            isr_r <= (isr_r
                   & ~((ack2 && aeoi_r) ? sel_bit : 8'h00)
                   & ~(spec_eoi ? eoi_bit : 8'h00))
                   | (ack1 ? sel_bit : 8'h00);
        end
    end

    // Acknowledge sequencing; poll and fully nested mode are not provided.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            inta_d_r  <= 1'b0;
            inta_ph_r <= 1'b0;
            sel_r     <= '0;
            intr_r    <= 1'b0;
            vec_r     <= '0;
        end else begin
            inta_d_r <= i_inta;
            if (inta_rise) inta_ph_r <= !inta_ph_r;
            if (!inta_ph_r && !inta_rise) sel_r <= req_b[2:0];
            if (ack2) vec_r <= vbase_r | {5'h00, sel_r};
            intr_r <= grant && !inta_ph_r && !ack1 && st_r == irq_timer_pkg::ST_IDLE;
        end
    end

    // Initialization words and operation commands; slave copies only store.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r <= irq_timer_pkg::ST_IDLE;
            imr_r <= irq_timer_pkg::MASK_RST;
            vbase_r <= '0;
            aeoi_r <= 1'b0;
            smm_r <= 1'b0;
            alt_r <= 1'b0;
            sicw_r <= '0;
            svbase_r <= '0;
            simr_r <= irq_timer_pkg::MASK_RST;
            sinit_r <= 1'b0;
            sst_r <= '0;
        end else begin
            if (icw1) begin
                st_r <= irq_timer_pkg::ST_IW2;
                imr_r <= '0;
                smm_r <= 1'b0;
            end else if (w_mdata) begin
                case (st_r)
                    irq_timer_pkg::ST_IW2: begin
                        vbase_r <= {i_wdata[7:3], 3'b000};
                        st_r <= irq_timer_pkg::ST_IW3;
                    end
                    irq_timer_pkg::ST_IW3: st_r <= irq_timer_pkg::ST_IW4;
                    irq_timer_pkg::ST_IW4: begin
                        aeoi_r <= i_wdata[irq_timer_pkg::B_AEOI];
                        st_r <= irq_timer_pkg::ST_IDLE;
                    end
                    default: imr_r <= i_wdata;
                endcase
            end
            if (ocw3 && i_wdata[irq_timer_pkg::B_SMMSET])
                smm_r <= i_wdata[irq_timer_pkg::B_SMM];
            if (ocw2 && i_wdata[7:5] == irq_timer_pkg::ROT_SET)
                alt_r <= i_wdata[2:0] != 3'd7;
            if (w_scmd && i_wdata[irq_timer_pkg::B_INIT]) begin
                sicw_r <= i_wdata;
                sinit_r <= 1'b1;
                sst_r <= 2'd0;
            end
            if (w_sdata) begin
                if (sinit_r && sst_r == 2'd0) svbase_r <= i_wdata;
                else if (!sinit_r) simr_r <= i_wdata;
                if (sinit_r) sst_r <= sst_r + 2'd1;
                if (sinit_r && sst_r == 2'd2) sinit_r <= 1'b0;
            end
        end
    end

    // System error and nmi; clock address writes stay local.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            nmisc_r <= '0;
            nmien_r <= 1'b1;
            cmos_r <= '0;
            nmi_r <= 1'b0;
            serr_d_r <= 1'b0;
            en_d_r <= 1'b0;
        end else begin
            if (i_wr && i_addr == irq_timer_pkg::ADR_NMISC) nmisc_r <= i_wdata;
            if (i_wr && i_addr == irq_timer_pkg::ADR_NMIEN) begin
                nmien_r <= !i_wdata[irq_timer_pkg::B_NMIEN];
                cmos_r <= i_wdata[6:0];
            end
            serr_d_r <= i_serr && !nmisc_r[irq_timer_pkg::B_NMIOFF];
            en_d_r <= nmien_r;
            // A new edge appears when enabled with the source still pending.
            nmi_r <= i_serr && !nmisc_r[irq_timer_pkg::B_NMIOFF] && nmien_r
                     && !(serr_d_r && en_d_r);
        end
    end

    // Timer clock enable: 27/28/28 repeating, 27/27/28 in cycle 34.
    wire [4:0] div_len = (sub_r == 2'd0 || (sub_r == 2'd1 && cyc_r == irq_timer_pkg::LAST_CYC))
                         ? irq_timer_pkg::DIV_A : irq_timer_pkg::DIV_B;
    wire tclk_en = div_r == div_len - 5'd1;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_r <= '0;
            sub_r <= '0;
            cyc_r <= '0;
        end else if (tclk_en) begin
            div_r <= '0;
            sub_r <= (sub_r == 2'd2) ? 2'd0 : sub_r + 2'd1;
            if (sub_r == 2'd2)
                cyc_r <= (cyc_r == irq_timer_pkg::LAST_CYC) ? 6'd0 : cyc_r + 6'd1;
        end else begin
            div_r <= div_r + 5'd1;
        end
    end

    // Counter 0 in binary rate-generator mode; read-back is not provided.
    wire latch_cmd = w_tctl && i_wdata[7:4] == irq_timer_pkg::LATCH_CMD;
    // Only counter 0 takes a mode word; read-back and other counters fall through.
    wire mode_cmd  = w_tctl && i_wdata[7:6] == 2'b00 && !latch_cmd
                     && i_wdata[5:4] != irq_timer_pkg::RW_LATCH;
    wire [15:0] init_nxt = (rwm_r == irq_timer_pkg::RW_LSB) ? {8'h00, i_wdata} :
                           (rwm_r == irq_timer_pkg::RW_MSB) ? {i_wdata, 8'h00} : {i_wdata, lsb_r};
    wire load_done = w_cnt && (rwm_r != 2'd3 || !lo_next_r);
    wire [15:0] rd_cnt = latched_r ? latch_r : cnt_r;
    wire rd_last = rwm_r != 2'd3 || !rlo_next_r;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= '0; init_r <= '0; latch_r <= '0; rwm_r <= 2'd3;
            latched_r <= 1'b0; lo_next_r <= 1'b1; rlo_next_r <= 1'b1;
            run_r <= 1'b0; tick_r <= 1'b0; lsb_r <= '0;
        end else begin
            if (mode_cmd) begin
                rwm_r <= i_wdata[5:4];
                run_r <= 1'b0;
                lo_next_r <= 1'b1;
                rlo_next_r <= 1'b1;
                latched_r <= 1'b0;
            end
            if (w_cnt) begin
                lsb_r <= i_wdata;
                if (rwm_r == 2'd3) lo_next_r <= !lo_next_r;
            end
            if (load_done) begin
                init_r <= init_nxt;
                cnt_r <= init_nxt;
                run_r <= 1'b1;
            end else if (run_r && tclk_en) begin
                tick_r <= cnt_r == 16'h0002;
                cnt_r <= (cnt_r == 16'h0001) ? init_r : cnt_r - 16'h0001;
            end
            if (latch_cmd && !latched_r) begin
                latch_r <= cnt_r;
                latched_r <= 1'b1;
            end else if (r_cnt) begin
                if (rwm_r == 2'd3) rlo_next_r <= !rlo_next_r;
                if (rd_last) latched_r <= 1'b0;
            end
        end
    end

    // Read multiplexer, fixed routing values included.
    wire [7:0] rd_mux =
        (i_addr == irq_timer_pkg::ADR_MCMD)    ? irr_r :
        (i_addr == irq_timer_pkg::ADR_MDATA)   ? imr_r :
        (i_addr == irq_timer_pkg::ADR_SCMD)    ? sicw_r :
        (i_addr == irq_timer_pkg::ADR_SDATA)   ? (sinit_r ? svbase_r : simr_r) :
        (i_addr == irq_timer_pkg::ADR_CNT0)    ?
            ((rwm_r == irq_timer_pkg::RW_MSB || (rwm_r == 2'd3 && !rlo_next_r))
             ? rd_cnt[15:8] : rd_cnt[7:0]) :
        (i_addr == irq_timer_pkg::ADR_NMISC)   ?
            {i_serr, nmisc_r[6:0]} :
        (i_addr == irq_timer_pkg::ADR_NMIEN)   ? {!nmien_r, cmos_r} :
        (i_addr == irq_timer_pkg::ADR_ROUTE_A) ? irq_timer_pkg::ROUTE_A_VAL :
        (i_addr == irq_timer_pkg::ADR_ROUTE_B || i_addr == irq_timer_pkg::ADR_ROUTE_C ||
         i_addr == irq_timer_pkg::ADR_ROUTE_D) ? irq_timer_pkg::ROUTE_OFF_VAL : 8'h00;
    always_ff @(posedge i_clk) begin
        if (i_rst) rdata_r <= '0;
        else rdata_r <= i_rd ? rd_mux : 8'h00;
    end

    // Outputs come straight from flip-flops.
    assign o_rdata  = rdata_r;
    assign o_intr   = intr_r;
    assign o_nmi    = nmi_r;
    assign o_vector = vec_r;
    assign o_tick   = tick_r;

    // Checks next to the logic they guard.
    property p_irq_cap;
        @(posedge i_clk) disable iff (i_rst) i_ser1_irq |=> irr_r[3];
    endproperty
    a_irq_cap: assert property (p_irq_cap) else $error("serial request lost");
    property p_mask;
        @(posedge i_clk) disable iff (i_rst) (imr_r == irq_timer_pkg::MASK_RST) |=> !o_intr;
    endproperty
    a_mask: assert property (p_mask) else $error("interrupt with all lines masked");
    property p_intr_release;
        @(posedge i_clk) disable iff (i_rst) ack1 |=> !o_intr;
    endproperty
    a_intr_release: assert property (p_intr_release) else $error("intr held after ack");
    property p_aeoi;
        @(posedge i_clk) disable iff (i_rst) (ack2 && aeoi_r && !ack1) |=> !isr_r[$past(sel_r)];
    endproperty
    a_aeoi: assert property (p_aeoi) else $error("auto end failed");
    property p_eoi;
        @(posedge i_clk) disable iff (i_rst) (spec_eoi && !ack1) |=> !isr_r[$past(i_wdata[2:0])];
    endproperty
    a_eoi: assert property (p_eoi) else $error("specific end failed");
    property p_nmi_block;
        @(posedge i_clk) disable iff (i_rst) !nmien_r |=> !o_nmi;
    endproperty
    a_nmi_block: assert property (p_nmi_block) else $error("nmi while disabled");
    property p_tick_one;
        @(posedge i_clk) disable iff (i_rst) $rose(o_tick) |=> o_tick [*2];
    endproperty
    a_tick_one: assert property (p_tick_one) else $error("tick too short");
    property p_div;
        @(posedge i_clk) disable iff (i_rst) tclk_en |=> !tclk_en [*8];
    endproperty
    a_div: assert property (p_div) else $error("enable spacing wrong");
    property p_route;
        @(posedge i_clk) disable iff (i_rst)
            (i_rd && i_addr == irq_timer_pkg::ADR_ROUTE_A) |=> o_rdata == irq_timer_pkg::ROUTE_A_VAL;
    endproperty
    a_route: assert property (p_route) else $error("routing value wrong");
    c_ack: cover property (@(posedge i_clk) disable iff (i_rst) ack1 ##[1:20] ack2);
    c_tick: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_tick));
    c_nmi: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_nmi));
endmodule

// >>> bench/cpu_bfm.sv
/*
 * Host processor model: I/O writes and reads, interrupt acknowledges, and the
 * command sequences that software issues to the controller and the timer.
 * Assumes one clock shared with the device and read data one cycle after the strobe.
 */
`timescale 1ns/100ps
module cpu_bfm (
    // Clock.
    input  wire logic        i_clk,
    // Register port and acknowledge.
    output logic      [11:0] o_addr,
    output logic      [7:0]  o_wdata,
    output logic             o_wr,
    output logic             o_rd,
    output logic             o_inta,
    input  wire logic [7:0]  i_rdata
);
    // The bus starts idle.
    initial begin
        o_addr  = 12'h000;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_inta  = 1'b0;
    end

    // One write cycle; a released bus shows inverted values so stale data never matches.
    task automatic wr(input logic [11:0] a, input logic [7:0] dat);
        @(posedge i_clk);
        o_wr    <= 1'b1;
        o_addr  <= a;
        o_wdata <= dat;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~dat;
    endtask

    // One read cycle; the data are taken in the cycle after the strobe.
    task automatic rd(input logic [11:0] a, output logic [7:0] dat);
        @(posedge i_clk);
        o_rd   <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        @(posedge i_clk);
        dat = i_rdata;
    endtask

    // Two acknowledge cycles, then time for the vector to land.
    task automatic ack();
        repeat (2) begin
            @(posedge i_clk);
            o_inta <= 1'b1;
            @(posedge i_clk);
            o_inta <= 1'b0;
        end
        repeat (3) @(posedge i_clk);
    endtask

    // Four initialization words followed by the mask word.
    task automatic init(input logic [11:0] a, input logic [7:0] vb, input logic [7:0] w4,
                        input logic [7:0] mask);
        wr(a, 8'h11);
        wr(a + 12'h001, vb);
        wr(a + 12'h001, 8'h04);
        wr(a + 12'h001, w4);
        wr(a + 12'h001, mask);
    endtask

    // Specific end of service for one level.
    task automatic end_of_service_command(input logic [2:0] ln);
        wr(irq_timer_pkg::ADR_MCMD, {irq_timer_pkg::EOI_SPEC, 2'b00, ln});
    endtask

    // Control word first, then the count bytes in the format it selects.
    task automatic load(input logic [7:0] ctl, input logic [15:0] cnt);
        wr(irq_timer_pkg::ADR_TCTL, ctl);
        if (ctl[4]) wr(irq_timer_pkg::ADR_CNT0, cnt[7:0]);
        if (ctl[5]) wr(irq_timer_pkg::ADR_CNT0, cnt[15:8]);
    endtask
endmodule

// >>> bench/tb_irq_timer.sv
/*
 * Self-checking bench of the interrupt and tick timer block with random requests.
 * Assumes the host model is compiled before it and drives the register port.
 */
`timescale 1ns/100ps
module tb_irq_timer;
    localparam logic [7:0]  VB = 8'h48;
    localparam logic [11:0] MC = irq_timer_pkg::ADR_MCMD;
    localparam logic [11:0] MD = irq_timer_pkg::ADR_MDATA;
    logic        i_clk, i_rst, i_wr, i_rd, i_inta, i_serr, o_intr, o_nmi, o_tick;
    logic        i_ser1_irq, i_ser2_irq, i_pci_irq_a;
    logic [11:0] i_addr;
    logic [7:0]  i_wdata, o_rdata, o_vector, d, lo;
    logic [15:0] va, vb;
    logic [2:0]  rq, mk;
    int          n_mismatch, n_compared, seed, nmi_n, t, per, sum;

    irq_timer irq_timer_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ser1_irq(i_ser1_irq),
        .i_ser2_irq(i_ser2_irq), .i_pci_irq_a(i_pci_irq_a), .i_serr(i_serr), .i_inta(i_inta),
        .o_intr(o_intr), .o_nmi(o_nmi), .o_vector(o_vector), .o_tick(o_tick));
    cpu_bfm cpu_bfm_inst (.i_clk(i_clk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
        .o_rd(i_rd), .o_inta(i_inta), .i_rdata(o_rdata));

    // The clock runs at 20 MHz; cycles with o_nmi high are counted as they appear.
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (o_nmi === 1'b1) nmi_n++;

    task automatic report_and_stop();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bounded wait for a level on o_intr (sel 0) or o_tick (sel 1); t holds the cycles spent minus one.
    task automatic wait_lvl(input int sel, input logic lvl, input int lim);
        for (t = 0; t < lim; t++) begin
            @(posedge i_clk);
            if ((sel == 0 ? o_intr : o_tick) === lvl) return;
        end
        chk("wait", 16'h0000, 16'h0001);
        report_and_stop();
    endtask
    // One-cycle request pulses on lines 3, 4 and 5.
    task automatic pulse(input logic [2:0] b);
        @(posedge i_clk);
        {i_pci_irq_a, i_ser2_irq, i_ser1_irq} <= b;
        @(posedge i_clk);
        {i_pci_irq_a, i_ser2_irq, i_ser1_irq} <= 3'h0;
    endtask
    // Expected vector: programmed base with the line number in the low bits.
    function automatic logic [15:0] exp_vec(input logic [2:0] ln);
        exp_vec = {8'h00, VB[7:3], ln};
    endfunction
    task automatic serve(input logic [2:0] ln);
        wait_lvl(0, 1'b1, 50);
        cpu_bfm_inst.ack();
        chk("vector", {8'h00, o_vector}, exp_vec(ln));
    endtask
    task automatic rd16(output logic [15:0] v);
        cpu_bfm_inst.rd(irq_timer_pkg::ADR_CNT0, lo);
        cpu_bfm_inst.rd(irq_timer_pkg::ADR_CNT0, d);
        v = {d, lo};
    endtask

    // Main sequence: reset, fixed registers, system error, requests, timer.
    initial begin
        seed = 32'he1f4;
        {i_rst, i_serr, i_ser1_irq, i_ser2_irq, i_pci_irq_a} = 5'h10;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        chk("idle", {13'h0000, o_intr, o_nmi, o_tick}, 16'h0000);
        cpu_bfm_inst.rd(MD, d);
        chk("mask", {8'h00, d}, 16'h00ff);
        cpu_bfm_inst.rd(irq_timer_pkg::ADR_ROUTE_A, d);
        chk("route", {8'h00, d}, 16'h0005);
        for (int i = 0; i < 3; i++) begin
            cpu_bfm_inst.rd(irq_timer_pkg::ADR_ROUTE_B + 12'(i), d);
            chk("route", {8'h00, d}, 16'h0080);
        end
        cpu_bfm_inst.rd(12'h123, d);
        chk("unmapped", {8'h00, d}, 16'h0000);
        cpu_bfm_inst.init(irq_timer_pkg::ADR_SCMD, 8'h50, 8'h01, 8'h5a);
        cpu_bfm_inst.rd(irq_timer_pkg::ADR_SDATA, d);
        chk("slave", {8'h00, d}, 16'h005a);
        cpu_bfm_inst.wr(irq_timer_pkg::ADR_NMISC, 8'h00);
        cpu_bfm_inst.wr(irq_timer_pkg::ADR_NMIEN, 8'h00);
        i_serr <= 1'b1;
        repeat (10) @(posedge i_clk);
        chk("nmi", 16'(nmi_n), 16'h0001);
        cpu_bfm_inst.rd(irq_timer_pkg::ADR_NMISC, d);
        chk("serr", {15'h0000, d[7]}, 16'h0001);
        cpu_bfm_inst.wr(irq_timer_pkg::ADR_NMIEN, 8'h95);
        cpu_bfm_inst.rd(irq_timer_pkg::ADR_NMIEN, d);
        chk("nmien", {8'h00, d}, 16'h0095);
        cpu_bfm_inst.wr(irq_timer_pkg::ADR_NMIEN, 8'h00);
        repeat (10) @(posedge i_clk);
        chk("nmi", 16'(nmi_n), 16'h0002);
        i_serr <= 1'b0;
        cpu_bfm_inst.wr(irq_timer_pkg::ADR_NMISC, 8'h04);
        i_serr <= 1'b1;
        repeat (10) @(posedge i_clk);
        chk("nmi", 16'(nmi_n), 16'h0002);
        i_serr <= 1'b0;
        // Random requests and masks with automatic end of service.
        cpu_bfm_inst.init(MC, VB, 8'h03, 8'hc7);
        for (int it = 0; it < 8; it++) begin
            rq = 3'($random(seed));
            mk = 3'($random(seed));
            if (rq == 3'h0) rq = 3'h5;
            cpu_bfm_inst.wr(MD, {2'b11, mk, 3'b111});
            pulse(rq);
            for (int k = 0; k < 3; k++) if (rq[k] && !mk[k]) serve(3'(k + 3));
            cpu_bfm_inst.wr(MD, 8'hc7);
            for (int k = 0; k < 3; k++) if (rq[k] && mk[k]) serve(3'(k + 3));
            repeat (10) @(posedge i_clk);
            chk("quiet", {15'h0000, o_intr}, 16'h0000);
        end
        // Specific end of service, blocking by in-service level, special mask.
        cpu_bfm_inst.init(MC, VB, 8'h01, 8'hc7);
        pulse(3'h1);
        serve(3'h3);
        chk("released", {15'h0000, o_intr}, 16'h0000);
        pulse(3'h2);
        repeat (20) @(posedge i_clk);
        chk("blocked", {15'h0000, o_intr}, 16'h0000);
        cpu_bfm_inst.end_of_service_command(3'h3);
        serve(3'h4);
        cpu_bfm_inst.end_of_service_command(3'h4);
        cpu_bfm_inst.wr(MC, 8'h68);
        pulse(3'h2);
        serve(3'h4);
        cpu_bfm_inst.wr(MD, 8'hd7);
        pulse(3'h4);
        serve(3'h5);
        cpu_bfm_inst.end_of_service_command(3'h5);
        cpu_bfm_inst.end_of_service_command(3'h4);
        cpu_bfm_inst.wr(MC, 8'h48);
        // Counter latch holds the count until both bytes are read.
        cpu_bfm_inst.load(8'h34, 16'h0100);
        repeat (600) @(posedge i_clk);
        cpu_bfm_inst.wr(irq_timer_pkg::ADR_TCTL, 8'hc0);
        rd16(va);
        cpu_bfm_inst.wr(irq_timer_pkg::ADR_TCTL, 8'hc0);
        repeat (560) @(posedge i_clk);
        rd16(vb);
        chk("count", {15'h0000, va > 16'h00e0 && va < 16'h00f0}, 16'h0001);
        chk("latch", {15'h0000, va - vb <= 16'h0001}, 16'h0001);
        // Both priority orders between the timer line and line 3.
        for (int o = 0; o < 2; o++) begin
            cpu_bfm_inst.wr(MD, 8'hff);
            wait_lvl(1, 1'b0, 8000);
            wait_lvl(1, 1'b1, 8000);
            wait_lvl(1, 1'b0, 40);
            pulse(3'h1);
            cpu_bfm_inst.wr(MC, o == 0 ? 8'hc7 : 8'hc2);
            cpu_bfm_inst.wr(MD, 8'hf6);
            serve(o == 0 ? 3'h0 : 3'h3);
            cpu_bfm_inst.end_of_service_command(o == 0 ? 3'h0 : 3'h3);
            serve(o == 0 ? 3'h3 : 3'h0);
            cpu_bfm_inst.end_of_service_command(o == 0 ? 3'h3 : 3'h0);
        end
        // Tick shape and spacing over one full divider pattern.
        cpu_bfm_inst.load(8'h14, 16'h0003);
        wait_lvl(1, 1'b0, 8000);
        wait_lvl(1, 1'b1, 8000);
        wait_lvl(1, 1'b0, 40);
        wait_lvl(1, 1'b1, 100);
        sum = 0;
        for (int p = 0; p < 35; p++) begin
            wait_lvl(1, 1'b0, 40);
            per = t + 1;
            chk("tick_hi", {15'h0000, per == 27 || per == 28}, 16'h0001);
            wait_lvl(1, 1'b1, 100);
            per = per + t + 1;
            sum = sum + per;
            chk("tick_per", {15'h0000, per == 82 || per == 83}, 16'h0001);
        end
        chk("tick_sum", 16'(sum), 16'h0b58);
        report_and_stop();
    end
endmodule
